// ==== rtl/auto_reload_timer_four_consts.vh ====
// Register offsets, field positions and reset values of the auto-reload timer
`ifndef AUTO_RELOAD_TIMER_FOUR_CONSTS_VH
`define AUTO_RELOAD_TIMER_FOUR_CONSTS_VH
`define TMR_OFS_CTRL      4'h0
`define TMR_OFS_LOW       4'h4
`define TMR_OFS_HIGH      4'h8
`define TMR_OFS_AUX       4'hc
`define TMR_CTRL_RESET    8'h00
`define TMR_BIT_CLKSRC    0
`define TMR_BIT_RUN       1
`define TMR_MODE_LO       2
`define TMR_MODE_HI       3
`define TMR_PS_LO         4
`define TMR_PS_HI         5
`define TMR_BIT_RETRIG    6
`define TMR_BIT_OVF       7
`define TMR_MODE_PLAIN    2'b00
`define TMR_MODE_BAUD     2'b01
`define TMR_MODE_RISE     2'b10
`define TMR_MODE_FALL     2'b11
`define TMR_AUX_IE        0
`define TMR_AUX_RXSEL     1
`define TMR_AUX_TXSEL     2
`define TMR_RESP_OKAY     2'b00
`define TMR_RESP_SLVERR   2'b10
`endif

// ==== rtl/auto_reload_timer_four.v ====
// Auto-reload sixteen-bit timer with baud and edge-trigger modes, AXI4-Lite slave
// What this block does
// - Sixteen-bit up-counter seen as two byte registers.
// - Byte writes load reload; reads return counter.
// - Run bit counts; wrap sets overflow flag outside baud mode.
// - Every overflow copies reload into counter.
// - High-byte write also loads counter from reload.
// - Plain mode sets flag; enabled interrupt raised.
// - Clock-source bit picks pin clock or system.
// - Run bit never clears counter; preload first.
// - Compare drives pin, toggles it each overflow.
// - Baud mode reloads, never requests interrupt.
// - Baud equals clock/2/16/(65536 minus reload).
// - Receiver and transmitter pick timers independently.
// - Edge modes ignore clock-source, use system clock.
// - Edge modes arm, edge starts, overflow halts.
// - Edge while counting ignored unless retrigger set.
// - Count-enable set by edge, cleared by overflow.
// - Mode field: plain, baud, rising, falling.
// - Retrigger bit enables compare in plain mode.
// - Prescaler divides by 1, 8, 64, 256.
// - Pin clock counts falling edges, enables pull-up.
`include "auto_reload_timer_four_consts.vh"
`default_nettype none

module auto_reload_timer_four
(
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer_pin_i,
  output reg         timer_pin_o,
  output reg         timer_pin_oe_o,
  output reg         timer_pin_pullup_o,
  output reg         irq_o,
  output reg         baud_tick_o,
  input  wire        alt_baud_tick_i,
  output reg         rx_baud_tick_o,
  output reg         tx_baud_tick_o
);

  // Timer state and bus capture registers
  reg  [7:0]  ctrl_q;          // Timer control register
  reg  [2:0]  aux_q;           // Interrupt enable, receive and transmit timer select
  reg  [15:0] reload_q;        // Hidden reload register
  reg  [15:0] count_q;         // Live counter
  reg         count_en_q;      // Edge-mode count enable
  reg  [7:0]  pscnt_q;         // Prescaler counter
  reg  [4:0]  baud_div_q;      // Overflow divider by 2 x 16
  reg  [1:0]  pin_sync_q;      // Pin synchroniser
  reg         pin_last_q;      // Previous synchronised pin level
  reg  [3:0]  aw_addr_q;       // Captured write address
  reg         aw_have_q;       // Write address held
  reg  [31:0] w_data_q;        // Captured write data
  reg  [3:0]  w_strb_q;        // Captured byte strobes
  reg         w_have_q;        // Write data held

  wire [1:0] mode       = ctrl_q[`TMR_MODE_HI:`TMR_MODE_LO];
  wire       edge_mode  = mode[1];
  wire       run        = ctrl_q[`TMR_BIT_RUN];
  wire       retrig     = ctrl_q[`TMR_BIT_RETRIG];
  // Edge modes force the system clock whatever the source bit says
  wire       ext_clk    = ctrl_q[`TMR_BIT_CLKSRC] & ~edge_mode;
  wire       compare_on = (mode == `TMR_MODE_PLAIN) & retrig;
  wire       pin_s      = pin_sync_q[1];
  wire       pin_rise   = pin_s & ~pin_last_q;
  wire       pin_fall   = ~pin_s & pin_last_q;
  // Trigger edge chosen by the low mode bit
  wire       trig_edge  = edge_mode & (mode[0] ? pin_fall : pin_rise);

  // Prescaler terminal count for the selected ratio
  function [7:0] ps_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   ps_limit = 8'h00;
        2'b01:   ps_limit = 8'h07;
        2'b10:   ps_limit = 8'h3f;
        default: ps_limit = 8'hff;
      endcase
    end
  endfunction

  // External clock counts on falling pin edges; system clock counts every cycle
  wire src_tick  = ext_clk ? pin_fall : 1'b1;
  wire ps_wrap   = (pscnt_q == ps_limit(ctrl_q[`TMR_PS_HI:`TMR_PS_LO]));
  wire gate      = run & (~edge_mode | count_en_q);
  wire inc       = gate & src_tick & ps_wrap;
  wire overflow  = inc & (count_q == 16'hffff);
  wire retrig_ok = run & trig_edge & (~count_en_q | retrig);

  // Write path: a write fires once both address and data are held
  wire        wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire        wr_low  = wr_fire & (aw_addr_q == `TMR_OFS_LOW) & w_strb_q[0];
  wire        wr_high = wr_fire & (aw_addr_q == `TMR_OFS_HIGH) & w_strb_q[0];
  wire        wr_ctrl = wr_fire & (aw_addr_q == `TMR_OFS_CTRL) & w_strb_q[0];
  wire        wr_aux  = wr_fire & (aw_addr_q == `TMR_OFS_AUX) & w_strb_q[0];
  wire        wr_map  = (aw_addr_q == `TMR_OFS_CTRL) | (aw_addr_q == `TMR_OFS_LOW) |
                        (aw_addr_q == `TMR_OFS_HIGH) | (aw_addr_q == `TMR_OFS_AUX);

  // Pin synchroniser and edge history
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pin_sync_q <= 2'b11;
      pin_last_q <= 1'b1;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], timer_pin_i};
      pin_last_q <= pin_s;
    end
  end

  // Prescaler advances on each source tick while the timer is gated on
  always @(posedge clock_i)
  begin
    if (srst_i)
      pscnt_q <= 8'h00;
    else if (~gate)
      pscnt_q <= 8'h00;
    else if (src_tick)
      pscnt_q <= ps_wrap ? 8'h00 : pscnt_q + 8'h01;
  end

  // Reload, counter and edge-mode enable
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      reload_q   <= 16'h0000;
      count_q    <= 16'h0000;
      count_en_q <= 1'b0;
    end
    else
    begin
      // Byte writes land in the reload register; a high-byte write also loads the counter
      if (wr_low)
        reload_q[7:0] <= w_data_q[7:0];
      if (wr_high)
        reload_q[15:8] <= w_data_q[7:0];
      // High-byte write transfers the freshly assembled value at once
      if (wr_high)
        count_q <= {w_data_q[7:0], reload_q[7:0]};
      else if (overflow)
        count_q <= reload_q;
      else if (retrig_ok & count_en_q)
        count_q <= reload_q;
      else if (inc)
        count_q <= count_q + 16'h0001;
      // Enable is cleared on overflow; a same-cycle edge still wins if it may retrigger
      if (~edge_mode | ~run)
        count_en_q <= 1'b0;
      else if (retrig_ok)
        count_en_q <= 1'b1;
      else if (overflow)
        count_en_q <= 1'b0;
    end
  end

  // Control registers; the hardware-set flag beats a software clear
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ctrl_q <= `TMR_CTRL_RESET;
      aux_q  <= 3'b000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= w_data_q[7:0];
      if (overflow & (mode != `TMR_MODE_BAUD))
        ctrl_q[`TMR_BIT_OVF] <= 1'b1;
      if (wr_aux)
        aux_q <= w_data_q[2:0];
    end
  end

  // Pin outputs, interrupt and baud ticks, all registered
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      timer_pin_o        <= 1'b0;
      timer_pin_oe_o     <= 1'b0;
      timer_pin_pullup_o <= 1'b0;
      irq_o              <= 1'b0;
      baud_div_q         <= 5'h00;
      baud_tick_o        <= 1'b0;
      rx_baud_tick_o     <= 1'b0;
      tx_baud_tick_o     <= 1'b0;
    end
    else
    begin
      timer_pin_oe_o     <= compare_on;
      if (compare_on & overflow)
        timer_pin_o <= ~timer_pin_o;
      timer_pin_pullup_o <= ext_clk;
      // Baud mode never requests an interrupt
      irq_o <= ctrl_q[`TMR_BIT_OVF] & aux_q[`TMR_AUX_IE] &
               (mode != `TMR_MODE_BAUD);
      // Overflows divided by 32 give the serial bit rate
      if (overflow & (mode == `TMR_MODE_BAUD))
        baud_div_q <= baud_div_q + 5'h01;
      baud_tick_o    <= overflow & (mode == `TMR_MODE_BAUD) & (baud_div_q == 5'h1f);
      // Each direction may take its rate from this timer or the other one
      rx_baud_tick_o <= aux_q[`TMR_AUX_RXSEL] ? alt_baud_tick_i :
                        (overflow & (mode == `TMR_MODE_BAUD) & (baud_div_q == 5'h1f));
      tx_baud_tick_o <= aux_q[`TMR_AUX_TXSEL] ? alt_baud_tick_i :
                        (overflow & (mode == `TMR_MODE_BAUD) & (baud_div_q == 5'h1f));
    end
  end

  // AXI4-Lite write channels: address and data taken independently
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TMR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        // Full address kept so that an unaligned write is refused, not aliased
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      // Channels reopen only after the response is taken
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; data registers return the live count
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TMR_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `TMR_RESP_OKAY;
      // Unaligned or unused addresses read as zero
      case (s_axi_araddr)
        `TMR_OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
        `TMR_OFS_LOW:  s_axi_rdata <= {24'h000000, count_q[7:0]};
        `TMR_OFS_HIGH: s_axi_rdata <= {24'h000000, count_q[15:8]};
        `TMR_OFS_AUX:  s_axi_rdata <= {29'h00000000, aux_q};
        default:       s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // auto_reload_timer_four

`default_nettype wire

// ==== tb/auto_reload_timer_four_asserts.sv ====
// Port-level timing checks for the auto-reload timer
`default_nettype none
module auto_reload_timer_four_asserts
(
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        alt_baud_tick_i,
  input wire logic        baud_tick_o,
  input wire logic        rx_baud_tick_o,
  input wire logic        tx_baud_tick_o,
  input wire logic        timer_pin_o,
  input wire logic        timer_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Address and data taken together
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (both_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_write_refused: assert property (both_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted early");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  // Bit-rate tick is one overflow in 32, so it never repeats soon
  a_baud_tick_pulse: assert property (baud_tick_o |=> !baud_tick_o [*8])
    else $error("baud tick too frequent");
  a_rx_tick_source: assert property (rx_baud_tick_o |-> baud_tick_o || $past(baud_tick_o) || $past(alt_baud_tick_i))
    else $error("receive tick without a source");
  a_tx_tick_source: assert property (tx_baud_tick_o |-> baud_tick_o || $past(baud_tick_o) || $past(alt_baud_tick_i))
    else $error("transmit tick without a source");
  a_pin_quiet: assert property (!timer_pin_oe_o && !$past(timer_pin_oe_o) |-> $stable(timer_pin_o))
    else $error("compare output moved while not driving");
endmodule // auto_reload_timer_four_asserts
bind auto_reload_timer_four auto_reload_timer_four_asserts u_chk (.clock_i, .srst_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .alt_baud_tick_i,
  .baud_tick_o, .rx_baud_tick_o, .tx_baud_tick_o, .timer_pin_o, .timer_pin_oe_o);
`default_nettype wire

// ==== tb/pin_partner.sv ====
// Far-side model: external pin source and the other timer's baud tick
`default_nettype none
module pin_partner
(
  input  wire logic clock_i,
  input  wire logic pulse_i,
  output var  logic pin_o,
  output var  logic alt_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q; // Free-running divider for the other timer
  logic [2:0] low_q; // Cycles left with the pin pulled low
  // Pin idles high, as the pull-up holds it
  initial
  begin
    pin_o = 1'b1;
    alt_tick_o = 1'b0;
    cnt_q = 4'h0;
    low_q = 3'h0;
  end
  // Each request gives one fall and one rise, five cycles apart, far below half the clock
  always @(posedge clock_i)
  begin
    cnt_q <= cnt_q + 4'h1;
    alt_tick_o <= (cnt_q == 4'hf);
    low_q <= pulse_i ? 3'h4 : (low_q != 3'h0 ? low_q - 3'h1 : 3'h0);
    pin_o <= !pulse_i && (low_q == 3'h0);
  end
endmodule // pin_partner
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the auto-reload timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, srst_i = 1'b1, pulse = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic timer_pin_o, timer_pin_oe_o, timer_pin_pullup_o, irq_o, baud_tick_o;
  logic alt_baud_tick_i, rx_baud_tick_o, tx_baud_tick_o;
  wire logic timer_pin_i = timer_pin_oe_o ? timer_pin_o : ext_pin; // Resolved pin level
  int n_errors = 0, total_checks = 0, c_pin, c_baud, c_rx, c_tx;
  int div[4] = '{1, 8, 64, 256};
  always #4 clock_i = ~clock_i;
  auto_reload_timer_four u_dut (.clock_i, .srst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_pin_i, .timer_pin_o, .timer_pin_oe_o, .timer_pin_pullup_o,
    .irq_o, .baud_tick_o, .alt_baud_tick_i, .rx_baud_tick_o, .tx_baud_tick_o);
  pin_partner u_far (.clock_i, .pulse_i(pulse), .pin_o(ext_pin), .alt_tick_o(alt_baud_tick_i));
  // Compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write: address and data offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task rdr(input logic [3:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Count pin toggles and tick pulses over n cycles
  task watch(input int n);
    logic p;
    {c_pin, c_baud, c_rx, c_tx} = '0;
    repeat (n)
    begin
      p = timer_pin_o;
      @(posedge clock_i);
      c_pin += (timer_pin_o !== p);
      c_baud += baud_tick_o;
      c_rx += rx_baud_tick_o;
      c_tx += tx_baud_tick_o;
    end
  endtask
  task fire;
    pulse <= 1'b1;
    @(posedge clock_i);
    pulse <= 1'b0;
    repeat (9) @(posedge clock_i);
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    rdr(4'h0); check("ctrl reset", rd, 0);
    rdr(4'h8); check("high reset", rd, 0);
    wr(4'h2, 1); check("unmapped resp", rs, 2'b10);
    rdr(4'h2); check("unmapped read", rd, 0);
    check("read resp", rs, 2'b00);
    // Plain mode: load, run past the top, flag and interrupt
    wr(4'h4, 32'hf0); wr(4'h8, 32'hff);
    rdr(4'h8); check("high loaded", rd, 32'hff);
    rdr(4'h4); check("low loaded", rd, 32'hf0);
    wr(4'hc, 1); wr(4'h0, 32'h02); repeat (40) @(posedge clock_i);
    rdr(4'h0); check("flag set", rd[7], 1);
    check("irq raised", irq_o, 1);
    rdr(4'h8); check("reloaded high", rd, 32'hff);
    // Stop first: an overflow in the clearing cycle would keep the flag set
    wr(4'h0, 0); wr(4'h0, 0);
    repeat (4) @(posedge clock_i); check("irq cleared", irq_o, 0);
    // Compare output at every prescale, reload at the top so each tick overflows
    wr(4'h4, 32'hff); wr(4'h8, 32'hff);
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(4'h0, 32'h42 | (ps << 4)); repeat (8) @(posedge clock_i); watch(512);
      check("pin toggles", c_pin, 512 / div[ps]);
      check("pin driven", timer_pin_oe_o, 1);
    end
    // Baud mode: tick per 32 overflows, transmit on the other timer, no interrupt
    wr(4'h0, 0); wr(4'hc, 5); wr(4'h0, 32'h06); repeat (8) @(posedge clock_i); watch(320);
    check("baud ticks", c_baud, 10);
    check("rx ticks", c_rx, 10);
    check("tx ticks", c_tx, 20);
    check("no baud irq", irq_o, 0);
    // Pin clock: each falling edge counts once
    wr(4'h0, 0); wr(4'h4, 0); wr(4'h8, 32'hff); wr(4'h0, 32'h03);
    repeat (5) fire;
    check("pull-up on", timer_pin_pullup_o, 1);
    rdr(4'h4); check("pin counts", rd, 5);
    // Edge modes, with and without retrigger; clock-source bit left set on purpose
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, 0); wr(4'h4, 0); wr(4'h8, 32'hff);
      wr(4'h0, ((m / 2) << 6) | ((2 + m % 2) << 2) | 3);
      repeat (20) @(posedge clock_i);
      rdr(4'h4); check("armed idle", rd, 0);
      fire; repeat (118) @(posedge clock_i); fire; repeat (150) @(posedge clock_i);
      rdr(4'h0); check("one-shot flag", rd[7], m < 2);
      rdr(4'h4);
      if (m < 2) check("halted at reload", rd, 0);
    end
    conclude;
  end
  initial
  begin
    #(8 * 20000);
    n_errors++;
    conclude;
  end
endmodule // testbench
`default_nettype wire
